//--- hw/uebc_cfg.svh
// Purpose: Constants for the USB endpoint buffer control block
// Assumes: Included by bare name from the package and the design
// Notes: Register window is 32 bytes per endpoint, one word per register
`ifndef UEBC_CFG_SVH
`define UEBC_CFG_SVH

// ==========================================================
// Bus layout
`define UEBC_ADDR_W 8
`define UEBC_DATA_W 16
`define UEBC_EP_LSB 5
`define UEBC_SEL_LSB 2

// ==========================================================
// Register index within an endpoint window (byte offset = 4 x index)
`define UEBC_REG_OUT_CSR 3'h0
`define UEBC_REG_IN_MAX_PACKET_LEN 3'h1
`define UEBC_REG_OUT_MAX_PACKET_LEN 3'h2
`define UEBC_REG_IN_CFG 3'h3
`define UEBC_REG_OUT_CFG 3'h4
`define UEBC_REG_RX_COUNT 3'h5
`define UEBC_REG_IN_DATA 3'h6
`define UEBC_REG_OUT_DATA 3'h7

// ==========================================================
// out_endpoint_control_status bit positions
`define UEBC_CSR_STS_LOW 0
`define UEBC_CSR_STS_HIGH 1
`define UEBC_CSR_OVERRUN 2
`define UEBC_CSR_OVERSIZE 3
`define UEBC_CSR_RX_ERR 4
`define UEBC_CSR_RELEASE 5
`define UEBC_CSR_OVR_CLR 6
`define UEBC_CSR_OSZ_CLR 7
`define UEBC_CSR_ERR_CLR 8
`define UEBC_CSR_TOG_INIT 9
`define UEBC_CSR_FLUSH 10
`define UEBC_CSR_ISO 11
`define UEBC_CSR_STALL 12
`define UEBC_CSR_AUTO 13

// ==========================================================
// Buffer config fields, start and size in 16-byte units
`define UEBC_CFG_W 15
`define UEBC_CFG_START_LSB 0
`define UEBC_CFG_SIZE_LSB 8
`define UEBC_CFG_DBL 14
`define UEBC_CFG_RST 15'h0000

// ==========================================================
// Lengths and reset values
`define UEBC_LEN_W 10
`define UEBC_MAX_PACKET_LEN_RST 10'h000
`define UEBC_MEM_BYTES 3072

`endif

//--- hw/uebc_pkg.sv
// Purpose: Types for the USB endpoint buffer control block
// Assumes: uebc_cfg.svh holds every number
// Notes: Used by scoped names only
`include "uebc_cfg.svh"

package uebc_pkg;

  // ==========================================================
  // Receive sequencer states
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_RECV
  } uebc_rx_state_t;

  typedef logic [`UEBC_LEN_W-1:0] uebc_len_t;
  typedef logic [`UEBC_CFG_W-1:0] uebc_cfg_t;

endpackage : uebc_pkg

//--- hw/uebc_top.sv
// Purpose: Endpoint buffer control of a USB function controller
// Assumes: Packet engine on sys_clk drives the rx and tx ports
// Notes: One shared byte buffer holds every endpoint's IN and OUT space
//
// Summary of operation
// - All IN and OUT max packet lengths reset to zero bytes.
// - Double buffering doubles an OUT endpoint's occupied buffer space.
// - OUT state flags follow reception, release writes and flush writes.
// - Isochronous OUT token with two sets held sets overrun flag.
// - Packet longer than max length sets oversize flag, answers STALL.
// - Isochronous OUT packet with CRC or stuffing error sets error flag.
// - CPU releases after reading; only while upper state flag is one.
// - Writing one to a clear bit resets its flag; zero does nothing.
// - Toggle init makes next expected OUT data PID DATA0.
// - Flush empties one set or drops the older of two.
// - Isochronous select bit makes the OUT endpoint isochronous.
// - Halt request bit answers every transaction with STALL.
// - Auto release frees the set once its bytes are read out.
// - Each good reception loads received count with the set's bytes.
// - Without auto release, received count stays constant during data port reads.
// - Release clears the received count of the released set only.
// - IN data port writes push into the endpoint transmit buffer.
// - OUT data port reads return next received byte of endpoint.
`include "uebc_cfg.svh"

module uebc_top #(
  parameter int NUM_EP = 5,
  parameter int MEM_BYTES = `UEBC_MEM_BYTES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [`UEBC_ADDR_W-1:0] regAddr,
  input wire logic [`UEBC_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`UEBC_DATA_W-1:0] regRdData,
  input wire logic rxToken,
  input wire logic [2:0] rxEp,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  input wire logic rxEnd,
  input wire logic rxDataPid1,
  input wire logic rxCrcErr,
  input wire logic rxStuffErr,
  output logic hsAck,
  output logic hsNak,
  output logic hsStall,
  input wire logic [2:0] txEp,
  input wire logic txRd,
  output logic [7:0] txData,
  output logic txAvail
);

  // ==========================================================
  // Parameter check
  if (NUM_EP < 1 || NUM_EP > 8 || MEM_BYTES < 16 || MEM_BYTES > 4096) begin
    $error("uebc_top: NUM_EP or MEM_BYTES out of range");
  end

  // ==========================================================
  // State
  logic [7:0] mem [MEM_BYTES];
  uebc_pkg::uebc_len_t inMaxp_q [NUM_EP];
  uebc_pkg::uebc_len_t outMaxp_q [NUM_EP];
  uebc_pkg::uebc_cfg_t inCfg_q [NUM_EP];
  uebc_pkg::uebc_cfg_t outCfg_q [NUM_EP];
  logic outIso_q [NUM_EP];
  logic outStall_q [NUM_EP];
  logic outAuto_q [NUM_EP];
  logic overrun_q [NUM_EP];
  logic oversize_q [NUM_EP];
  logic rxErr_q [NUM_EP];
  logic toggle_q [NUM_EP];
  logic [1:0] nSets_q [NUM_EP];
  logic wrSet_q [NUM_EP];
  logic rdSet_q [NUM_EP];
  uebc_pkg::uebc_len_t rxCnt_q [NUM_EP][2];
  uebc_pkg::uebc_len_t rdPtr_q [NUM_EP];
  uebc_pkg::uebc_len_t inWrPtr_q [NUM_EP];
  uebc_pkg::uebc_len_t inRdPtr_q [NUM_EP];
  uebc_pkg::uebc_rx_state_t rxState_q;
  logic [2:0] rxEp_q;
  uebc_pkg::uebc_len_t rxPtr_q;
  logic rxOver_q;
  logic [`UEBC_DATA_W-1:0] regRdData_q;
  logic [7:0] txData_q;
  logic hsAck_q;
  logic hsNak_q;
  logic hsStall_q;

  // ==========================================================
  // Address helpers
  function automatic logic [9:0] setBytes(input uebc_pkg::uebc_cfg_t c);
    setBytes = {c[`UEBC_CFG_SIZE_LSB +: 6], 4'h0};
  endfunction : setBytes

  function automatic logic [11:0] memAddr(input uebc_pkg::uebc_cfg_t c,
                                          input logic set,
                                          input uebc_pkg::uebc_len_t ptr);
    logic [11:0] base;
    logic [11:0] half;
    base = {c[`UEBC_CFG_START_LSB +: 8], 4'h0};
    half = {2'b00, setBytes(c)};
    memAddr = base + (set ? half : 12'h000) + {2'b00, ptr};
  endfunction : memAddr

  // ==========================================================
  // Bus decode
  logic [2:0] regEp;
  logic [2:0] regSel;
  logic regEpOk;
  logic [2:0] ep;
  assign regEp = regAddr[`UEBC_EP_LSB +: 3];
  assign regSel = regAddr[`UEBC_SEL_LSB +: 3];
  assign regEpOk = 32'(regEp) < NUM_EP;
  assign ep = regEpOk ? regEp : 3'h0;

  logic csrWr;
  logic outDataRd;
  logic inDataWr;
  assign csrWr = regWr && regEpOk && regSel == `UEBC_REG_OUT_CSR;
  assign outDataRd = regRd && regEpOk && regSel == `UEBC_REG_OUT_DATA;
  assign inDataWr = regWr && regEpOk && regSel == `UEBC_REG_IN_DATA;

  // ==========================================================
  // Receive side decisions
  logic [2:0] re;
  logic rxRoom;
  logic rxWrOk;
  logic rxErrNow;
  logic rxFinish;
  logic rxHalt;
  logic rxCommit;
  logic rxOversize;
  logic [11:0] rxAddr;
  assign re = rxEp_q;
  assign rxRoom = nSets_q[re] < (outCfg_q[re][`UEBC_CFG_DBL] ? 2'd2 : 2'd1);
  assign rxAddr = memAddr(outCfg_q[re], wrSet_q[re], rxPtr_q);
  assign rxWrOk = rxState_q == uebc_pkg::RX_RECV && rxByteValid &&
                  rxPtr_q < outMaxp_q[re] && rxPtr_q < setBytes(outCfg_q[re]) &&
                  rxRoom && !outStall_q[re] && 32'(rxAddr) < MEM_BYTES;
  assign rxErrNow = rxCrcErr || rxStuffErr;
  assign rxFinish = rxState_q == uebc_pkg::RX_RECV && rxEnd;
  assign rxOversize = rxFinish && rxOver_q;
  assign rxHalt = rxFinish && (outStall_q[re] || rxOver_q);
  assign rxCommit = rxFinish && !rxHalt && !rxErrNow && rxRoom &&
                    (outIso_q[re] || rxDataPid1 == toggle_q[re]);

  // ==========================================================
  // Release path: CPU release, flush or auto release
  logic [11:0] outRdAddr;
  logic autoRel;
  logic doRel;
  assign outRdAddr = memAddr(outCfg_q[ep], rdSet_q[ep], rdPtr_q[ep]);
  assign autoRel = outDataRd && outAuto_q[ep] && nSets_q[ep] != 2'd0 &&
                   rdPtr_q[ep] + 10'd1 >= rxCnt_q[ep][rdSet_q[ep]];
  assign doRel = nSets_q[ep] != 2'd0 && (autoRel || (csrWr &&
                 (regWrData[`UEBC_CSR_RELEASE] ||
                  regWrData[`UEBC_CSR_FLUSH])));

  // ==========================================================
  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_EP; i++) begin
        inMaxp_q[i] <= `UEBC_MAX_PACKET_LEN_RST;
        outMaxp_q[i] <= `UEBC_MAX_PACKET_LEN_RST;
        inCfg_q[i] <= `UEBC_CFG_RST;
        outCfg_q[i] <= `UEBC_CFG_RST;
        outIso_q[i] <= 1'b0;
        outStall_q[i] <= 1'b0;
        outAuto_q[i] <= 1'b0;
      end
    end else if (clkEn && regWr && regEpOk) begin
      case (regSel)
        `UEBC_REG_IN_MAX_PACKET_LEN: inMaxp_q[ep] <= regWrData[9:0];
        `UEBC_REG_OUT_MAX_PACKET_LEN: outMaxp_q[ep] <= regWrData[9:0];
        `UEBC_REG_IN_CFG: inCfg_q[ep] <= regWrData[14:0];
        `UEBC_REG_OUT_CFG: outCfg_q[ep] <= regWrData[14:0];
        `UEBC_REG_OUT_CSR: begin
          outIso_q[ep] <= regWrData[`UEBC_CSR_ISO];
          outStall_q[ep] <= regWrData[`UEBC_CSR_STALL];
          outAuto_q[ep] <= regWrData[`UEBC_CSR_AUTO];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Receive sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxState_q <= uebc_pkg::RX_IDLE;
      rxEp_q <= 3'h0;
      rxPtr_q <= 10'h000;
      rxOver_q <= 1'b0;
    end else if (clkEn) begin
      case (rxState_q)
        uebc_pkg::RX_IDLE: begin
          if (rxToken && 32'(rxEp) < NUM_EP) begin
            rxEp_q <= rxEp;
            rxPtr_q <= 10'h000;
            rxOver_q <= 1'b0;
            rxState_q <= uebc_pkg::RX_RECV;
          end
        end
        uebc_pkg::RX_RECV: begin
          if (rxByteValid) begin
            if (rxPtr_q >= outMaxp_q[re]) begin
              rxOver_q <= 1'b1;
            end else begin
              rxPtr_q <= rxPtr_q + 10'd1;
            end
          end
          if (rxEnd) begin
            rxState_q <= uebc_pkg::RX_IDLE;
          end
        end
        default: rxState_q <= uebc_pkg::RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Handshake answer, one cycle after the end of packet
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hsAck_q <= 1'b0;
      hsNak_q <= 1'b0;
      hsStall_q <= 1'b0;
    end else if (clkEn) begin
      hsStall_q <= rxHalt;
      hsNak_q <= rxFinish && !rxHalt && !rxErrNow && !outIso_q[re] &&
                 !rxRoom;
      hsAck_q <= rxFinish && !rxHalt && !rxErrNow && !outIso_q[re] &&
                 rxRoom;
    end
  end

  // ==========================================================
  // OUT buffer occupancy, counts and read pointer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_EP; i++) begin
        nSets_q[i] <= 2'd0;
        wrSet_q[i] <= 1'b0;
        rdSet_q[i] <= 1'b0;
        rxCnt_q[i][0] <= 10'h000;
        rxCnt_q[i][1] <= 10'h000;
        rdPtr_q[i] <= 10'h000;
      end
    end else if (clkEn) begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (rxCommit && 32'(re) == i) begin
          rxCnt_q[i][wrSet_q[i]] <= rxPtr_q;
          wrSet_q[i] <= wrSet_q[i] ^ outCfg_q[i][`UEBC_CFG_DBL];
        end
        if (doRel && 32'(ep) == i) begin
          rxCnt_q[i][rdSet_q[i]] <= 10'h000;
          rdSet_q[i] <= rdSet_q[i] ^ outCfg_q[i][`UEBC_CFG_DBL];
          rdPtr_q[i] <= 10'h000;
        end else if (outDataRd && 32'(ep) == i && nSets_q[i] != 2'd0) begin
          rdPtr_q[i] <= rdPtr_q[i] + 10'd1;
        end
        nSets_q[i] <= nSets_q[i] +
                      {1'b0, rxCommit && 32'(re) == i} -
                      {1'b0, doRel && 32'(ep) == i};
      end
    end
  end

  // ==========================================================
  // Sticky status flags, a set beats a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_EP; i++) begin
        overrun_q[i] <= 1'b0;
        oversize_q[i] <= 1'b0;
        rxErr_q[i] <= 1'b0;
      end
    end else if (clkEn) begin
      if (csrWr) begin
        if (regWrData[`UEBC_CSR_OVR_CLR]) overrun_q[ep] <= 1'b0;
        if (regWrData[`UEBC_CSR_OSZ_CLR]) oversize_q[ep] <= 1'b0;
        if (regWrData[`UEBC_CSR_ERR_CLR]) rxErr_q[ep] <= 1'b0;
      end
      if (rxState_q == uebc_pkg::RX_IDLE && rxToken &&
          32'(rxEp) < NUM_EP && outIso_q[rxEp] && nSets_q[rxEp] == 2'd2) begin
        overrun_q[rxEp] <= 1'b1;
      end
      if (rxOversize) oversize_q[re] <= 1'b1;
      if (rxFinish && rxErrNow && outIso_q[re]) begin
        rxErr_q[re] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Expected data PID per OUT endpoint
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_EP; i++) begin
        toggle_q[i] <= 1'b0;
      end
    end else if (clkEn) begin
      if (rxCommit && !outIso_q[re]) toggle_q[re] <= !toggle_q[re];
      if (csrWr && regWrData[`UEBC_CSR_TOG_INIT]) begin
        toggle_q[ep] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // IN transmit pointers
  logic [11:0] inWrAddr;
  logic [11:0] inRdAddr;
  logic inWrOk;
  logic txPop;
  assign inWrAddr = memAddr(inCfg_q[ep], 1'b0, inWrPtr_q[ep]);
  assign inRdAddr = memAddr(inCfg_q[txEp], 1'b0, inRdPtr_q[txEp]);
  assign inWrOk = inDataWr && inWrPtr_q[ep] < setBytes(inCfg_q[ep]) &&
                  32'(inWrAddr) < MEM_BYTES;
  assign txAvail = 32'(txEp) < NUM_EP && inRdPtr_q[txEp] != inWrPtr_q[txEp];
  assign txPop = txRd && txAvail;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_EP; i++) begin
        inWrPtr_q[i] <= 10'h000;
        inRdPtr_q[i] <= 10'h000;
      end
    end else if (clkEn) begin
      if (inWrOk) inWrPtr_q[ep] <= inWrPtr_q[ep] + 10'd1;
      if (txPop) begin
        if (inRdPtr_q[txEp] + 10'd1 == inWrPtr_q[txEp] &&
            !(inWrOk && ep == txEp)) begin
          inRdPtr_q[txEp] <= 10'h000;
          inWrPtr_q[txEp] <= 10'h000;
        end else begin
          inRdPtr_q[txEp] <= inRdPtr_q[txEp] + 10'd1;
        end
      end
    end
  end

  // ==========================================================
  // Shared byte buffer
  always_ff @(posedge sys_clk) begin
    if (clkEn) begin
      if (rxWrOk) mem[rxAddr] <= rxByte;
      if (inWrOk) mem[inWrAddr] <= regWrData[7:0];
    end
  end

  // ==========================================================
  // Register read data, valid the cycle after the strobe only
  logic [`UEBC_DATA_W-1:0] rdVal;
  always_comb begin
    rdVal = 16'h0000;
    case (regSel)
      `UEBC_REG_OUT_CSR: begin
        rdVal[`UEBC_CSR_STS_HIGH] = nSets_q[ep] != 2'd0;
        rdVal[`UEBC_CSR_STS_LOW] = nSets_q[ep] == 2'd2 ||
          (nSets_q[ep] == 2'd1 && !outCfg_q[ep][`UEBC_CFG_DBL]);
        rdVal[`UEBC_CSR_OVERRUN] = overrun_q[ep];
        rdVal[`UEBC_CSR_OVERSIZE] = oversize_q[ep];
        rdVal[`UEBC_CSR_RX_ERR] = rxErr_q[ep];
        rdVal[`UEBC_CSR_ISO] = outIso_q[ep];
        rdVal[`UEBC_CSR_STALL] = outStall_q[ep];
        rdVal[`UEBC_CSR_AUTO] = outAuto_q[ep];
      end
      `UEBC_REG_IN_MAX_PACKET_LEN: rdVal = {6'h00, inMaxp_q[ep]};
      `UEBC_REG_OUT_MAX_PACKET_LEN: rdVal = {6'h00, outMaxp_q[ep]};
      `UEBC_REG_IN_CFG: rdVal = {1'b0, inCfg_q[ep]};
      `UEBC_REG_OUT_CFG: rdVal = {1'b0, outCfg_q[ep]};
      `UEBC_REG_RX_COUNT: rdVal = {6'h00, rxCnt_q[ep][rdSet_q[ep]]};
      `UEBC_REG_OUT_DATA: begin
        if (nSets_q[ep] != 2'd0 && 32'(outRdAddr) < MEM_BYTES) begin
          rdVal = {8'h00, mem[outRdAddr]};
        end
      end
      default: rdVal = 16'h0000;
    endcase
    if (!regEpOk) rdVal = 16'h0000;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdData_q <= 16'h0000;
      txData_q <= 8'h00;
    end else if (clkEn) begin
      regRdData_q <= regRd ? rdVal : 16'h0000;
      if (txPop && 32'(inRdAddr) < MEM_BYTES) txData_q <= mem[inRdAddr];
    end
  end

  assign regRdData = regRdData_q;
  assign txData = txData_q;
  assign hsAck = hsAck_q;
  assign hsNak = hsNak_q;
  assign hsStall = hsStall_q;

endmodule : uebc_top

//--- tb/uebc_top_props.sv
// Purpose: Port-level checks of the endpoint buffer control block
// Assumes: Bound to uebc_top, one clock, clkEn held high except during one gated write
// Notes: Control bits and lengths are mirrored from register writes
`include "uebc_cfg.svh"
module uebc_top_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [`UEBC_ADDR_W-1:0] regAddr,
  input wire logic [`UEBC_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [`UEBC_DATA_W-1:0] regRdData,
  input wire logic rxToken,
  input wire logic [2:0] rxEp,
  input wire logic rxByteValid,
  input wire logic rxEnd,
  input wire logic rxCrcErr,
  input wire logic rxStuffErr,
  input wire logic hsAck,
  input wire logic hsNak,
  input wire logic hsStall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ctlQ [5];
  logic [9:0] lenQ [5];
  logic [2:0] epQ;
  logic [10:0] nQ;
  logic [2:0] wEp;
  logic [2:0] wIx;
  logic [2:0] ctl;
  assign wEp = regAddr[7:5];
  assign wIx = regAddr[4:2];
  assign ctl = ctlQ[epQ];

  // ==========================================================
  // Mirrors
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 5; i++)
        ctlQ[i] <= '0;
    end else if (regWr && wEp < 5 && wIx == `UEBC_REG_OUT_CSR) begin
      ctlQ[wEp] <= regWrData[13:11];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 5; i++)
        lenQ[i] <= '0;
    end else if (regWr && wEp < 5 && wIx == `UEBC_REG_OUT_MAX_PACKET_LEN) begin
      lenQ[wEp] <= regWrData[9:0];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      epQ <= '0;
      nQ <= '0;
    end else if (rxToken) begin
      epQ <= rxEp;
      nQ <= '0;
    end else if (rxByteValid) begin
      nQ <= nQ + 11'd1;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_clean_end;
    rxEnd && !rxCrcErr && !rxStuffErr;
  endsequence
  sequence s_bad_end;
    rxEnd && (rxCrcErr || rxStuffErr);
  endsequence

  a_hs_exclusive: assert property ($onehot0({hsAck, hsNak, hsStall}))
    else $error("more than one handshake at once");
  a_hs_cause: assert property ((hsAck || hsNak || hsStall) |-> $past(rxEnd))
    else $error("handshake without packet end one cycle before");
  a_rd_idle: assert property (!$past(regRd) |-> regRdData == '0)
    else $error("read data outside its cycle");
  a_rd_refused: assert property (regRd && regAddr[7:5] > 3'd4 |=> regRdData == '0)
    else $error("read of missing endpoint not zero");
  a_halt_stall: assert property (s_clean_end ##0 (ctl[1] && !ctl[0]) |=> hsStall)
    else $error("halted endpoint did not stall");
  a_halt_resume: assert property (s_clean_end ##0 (!ctl[1] && !ctl[0] && nQ <= 11'(lenQ[epQ])) |=> !hsStall)
    else $error("stall without halt or oversize");
  a_oversize_stall: assert property (s_clean_end ##0 (!ctl[0] && nQ > 11'(lenQ[epQ])) |=> hsStall)
    else $error("oversize packet not stalled");
  a_iso_quiet: assert property (rxEnd && ctl[0] |=> !hsAck && !hsNak)
    else $error("handshake on isochronous endpoint");
  a_err_quiet: assert property (s_bad_end |=> !hsAck)
    else $error("damaged packet acknowledged");
endmodule : uebc_top_props

//--- tb/uebc_host_model.sv
// Purpose: Host and packet engine model driving the rx and tx ports
// Assumes: Tasks are entered just after a rising edge
// Notes: Idle data byte shows the inverse of the last byte sent
module uebc_host_model (
  input wire logic sys_clk,
  output logic rxToken,
  output logic [2:0] rxEp,
  output logic rxByteValid,
  output logic [7:0] rxByte,
  output logic rxEnd,
  output logic rxDataPid1,
  output logic rxCrcErr,
  output logic rxStuffErr,
  output logic [2:0] txEp,
  output logic txRd,
  input wire logic [7:0] txData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {rxToken, rxByteValid, rxEnd, rxDataPid1, rxCrcErr, rxStuffErr} = '0;
    {rxEp, txEp, txRd} = '0;
    rxByte = 8'h5a;
  end
  // Token, bytes, end, then one idle cycle
  task send(input logic [2:0] ep, input logic [7:0] n, input logic pid1,
            input logic [1:0] err, input logic [7:0] b);
    rxEp <= ep;
    rxToken <= 1'b1;
    @(posedge sys_clk);
    rxToken <= 1'b0;
    for (int i = 0; i < int'(n); i++) begin
      rxByteValid <= 1'b1;
      rxByte <= b + 8'(i);
      @(posedge sys_clk);
    end
    rxByteValid <= 1'b0;
    rxByte <= ~rxByte;
    rxEnd <= 1'b1;
    rxDataPid1 <= pid1;
    {rxStuffErr, rxCrcErr} <= err;
    @(posedge sys_clk);
    rxEnd <= 1'b0;
    rxDataPid1 <= ~pid1;
    {rxStuffErr, rxCrcErr} <= 2'b00;
    @(posedge sys_clk);
  endtask : send
  task pop(input logic [2:0] ep, output logic [7:0] d);
    txEp <= ep;
    txRd <= 1'b1;
    @(posedge sys_clk);
    txRd <= 1'b0;
    @(posedge sys_clk);
    d = txData;
  endtask : pop
endmodule : uebc_host_model

//--- tb/uebc_top_tb.sv
// Purpose: Self-checking bench for the endpoint buffer control block
// Assumes: Host model drives rx and tx ports, clkEn held high except during one gated write
// Notes: Reads and handshakes are compared against queued notes
`include "uebc_cfg.svh"
module uebc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] CSR = `UEBC_REG_OUT_CSR;
  localparam logic [2:0] CNT = `UEBC_REG_RX_COUNT;
  localparam logic [2:0] ODT = `UEBC_REG_OUT_DATA;
  localparam logic [2:0] ACK = 3'h1;
  localparam logic [2:0] STL = 3'h4;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic rdPend = 1'b0;
  logic txPend = 1'b0;
  logic [15:0] regRdData;
  logic rxToken, rxByteValid, rxEnd, rxDataPid1, rxCrcErr, rxStuffErr, txRd;
  logic [2:0] rxEp, txEp;
  logic [7:0] rxByte, txData, base, b1, d;
  logic hsAck, hsNak, hsStall, txAvail;
  int nErrors = 0;
  int samplesChecked = 0;
  logic [31:0] seed = 32'h0000_ff17;
  logic [15:0] rdQ [$];
  logic [2:0] hsQ [$];
  logic [7:0] txQ [$];

  always #20 sys_clk = ~sys_clk;
  uebc_top dut (.sys_clk, .rst_n, .clkEn, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .rxToken, .rxEp, .rxByteValid, .rxByte, .rxEnd,
    .rxDataPid1, .rxCrcErr, .rxStuffErr, .hsAck, .hsNak, .hsStall, .txEp,
    .txRd, .txData, .txAvail);
  uebc_host_model host (.sys_clk, .rxToken, .rxEp, .rxByteValid, .rxByte,
    .rxEnd, .rxDataPid1, .rxCrcErr, .rxStuffErr, .txEp, .txRd, .txData);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task check(input string nm, input logic [15:0] s, input logic [15:0] e);
    samplesChecked++;
    if (s !== e) begin
      nErrors++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask : check
  task results();
    $display("checks %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task wr(input int ep, input logic [2:0] ix, input logic [15:0] v);
    regAddr <= {3'(ep), ix, 2'b00};
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task rd(input int ep, input logic [2:0] ix, input logic [15:0] e);
    regAddr <= {3'(ep), ix, 2'b00};
    regRd <= 1'b1;
    rdQ.push_back(e);
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  task pkt(input int ep, input int n, input int pid1,
           input logic [1:0] err, input logic [2:0] hs);
    seed = xs(seed);
    base = seed[7:0];
    if (hs != 3'h0)
      hsQ.push_back(hs);
    host.send(3'(ep), 8'(n), 1'(pid1), err, base);
    repeat (2) @(posedge sys_clk);
  endtask : pkt

  // ==========================================================
  // Result watcher
  always @(posedge sys_clk) begin
    if (rdPend)
      check("regRdData", regRdData, rdQ.pop_front());
    if ((hsAck | hsNak | hsStall) !== 1'b0)
      check("handshake", {13'h0000, hsStall, hsNak, hsAck},
            {13'h0000, hsQ.pop_front()});
    if (txPend)
      check("txData", {8'h00, txData}, {8'h00, txQ.pop_front()});
    rdPend <= regRd;
    txPend <= txRd;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    nErrors++;
    results();
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int e = 1; e < 5; e++) begin
      rd(e, `UEBC_REG_IN_MAX_PACKET_LEN, 16'h0000);
      rd(e, `UEBC_REG_OUT_MAX_PACKET_LEN, 16'h0000);
    end
    wr(1, `UEBC_REG_OUT_MAX_PACKET_LEN, 16'h0008);
    wr(2, `UEBC_REG_OUT_MAX_PACKET_LEN, 16'h0008);
    wr(1, `UEBC_REG_OUT_CFG, 16'h4100);
    wr(2, `UEBC_REG_OUT_CFG, 16'h4102);
    wr(3, `UEBC_REG_IN_CFG, 16'h0104);
    rd(1, `UEBC_REG_OUT_CFG, 16'h4100);
    pkt(1, 4, 0, 2'b00, ACK);
    b1 = base;
    rd(1, CNT, 16'h0004);
    rd(1, CSR, 16'h0002);
    pkt(1, 3, 1, 2'b00, ACK);
    rd(1, CSR, 16'h0003);
    for (int i = 0; i < 4; i++)
      rd(1, ODT, {8'h00, b1 + 8'(i)});
    rd(1, CNT, 16'h0004);
    wr(1, CSR, 16'h0020);
    rd(1, CNT, 16'h0003);
    rd(1, CSR, 16'h0002);
    wr(1, CSR, 16'h0400);
    rd(1, CSR, 16'h0000);
    rd(1, CNT, 16'h0000);
    pkt(1, 9, 0, 2'b00, STL);
    rd(1, CSR, 16'h0008);
    wr(1, CSR, 16'h0000);
    rd(1, CSR, 16'h0008);
    wr(1, CSR, 16'h0080);
    rd(1, CSR, 16'h0000);
    wr(1, CSR, 16'h1000);
    pkt(1, 2, 0, 2'b00, STL);
    rd(1, CSR, 16'h1000);
    wr(1, CSR, 16'h0000);
    pkt(1, 2, 0, 2'b00, ACK);
    rd(1, CNT, 16'h0002);
    wr(1, CSR, 16'h0020);
    wr(1, CSR, 16'h0200);
    pkt(1, 5, 0, 2'b00, ACK);
    b1 = base;
    rd(1, CNT, 16'h0005);
    wr(1, CSR, 16'h2000);
    for (int i = 0; i < 5; i++)
      rd(1, ODT, {8'h00, b1 + 8'(i)});
    rd(1, CNT, 16'h0000);
    rd(1, CSR, 16'h2000);
    wr(2, CSR, 16'h0800);
    pkt(2, 3, 0, 2'b01, 3'h0);
    pkt(2, 3, 0, 2'b10, 3'h0);
    rd(2, CSR, 16'h0810);
    pkt(2, 2, 0, 2'b00, 3'h0);
    pkt(2, 2, 1, 2'b00, 3'h0);
    pkt(2, 1, 0, 2'b00, 3'h0);
    rd(2, CSR, 16'h0817);
    wr(2, CSR, 16'h0940);
    rd(2, CSR, 16'h0803);
    wr(2, CSR, 16'h0000);
    pkt(2, 1, 0, 2'b00, 3'h2);
    seed = xs(seed);
    b1 = seed[7:0];
    for (int i = 0; i < 3; i++)
      wr(3, `UEBC_REG_IN_DATA, {8'h00, b1 + 8'(i)});
    for (int i = 0; i < 3; i++) begin
      txQ.push_back(b1 + 8'(i));
      host.pop(3'd3, d);
      check("txData", {8'h00, d}, {8'h00, b1 + 8'(i)});
      check("txAvail", 16'(txAvail), 16'(i < 2));
    end
    clkEn <= 1'b0;
    wr(1, `UEBC_REG_IN_MAX_PACKET_LEN, 16'h0003);
    clkEn <= 1'b1;
    rd(1, `UEBC_REG_IN_MAX_PACKET_LEN, 16'h0000);
    wr(5, `UEBC_REG_OUT_MAX_PACKET_LEN, 16'h0008);
    rd(5, `UEBC_REG_OUT_MAX_PACKET_LEN, 16'h0000);
    rd(1, `UEBC_REG_IN_DATA, 16'h0000);
    check("hsQueue", 16'(hsQ.size()), 16'h0000);
    results();
  end
endmodule : uebc_top_tb

bind uebc_top uebc_top_props chk (.sys_clk, .rst_n, .regAddr, .regWrData,
  .regWr, .regRd, .regRdData, .rxToken, .rxEp, .rxByteValid, .rxEnd,
  .rxCrcErr, .rxStuffErr, .hsAck, .hsNak, .hsStall);
